// ===== logic/dcwd_consts.vh
`ifndef DCWD_CONSTS_VH
`define DCWD_CONSTS_VH

// Register byte address of the drive command word
`define DCWD_ADDR_CMD_WORD 16'h6040
// Register byte address of the decoded command status (read only)
`define DCWD_ADDR_CMD_STAT 16'h6044
// Reset value of the drive command word
`define DCWD_CMD_WORD_RST 16'h0000

// Field positions inside the drive command word
`define DCWD_BIT_SWITCH_ON 0
`define DCWD_BIT_VOLTAGE 1
`define DCWD_BIT_NO_QSTOP 2
`define DCWD_BIT_ENABLE_OP 3
`define DCWD_BIT_MODE_LO 4
`define DCWD_BIT_MODE_HI 6
`define DCWD_BIT_FAULT_RST 7
`define DCWD_BIT_HALT 8
`define DCWD_BIT_BRAKE 14

// Device-state command encodings
`define DCWD_CMD_NONE 3'h0
`define DCWD_CMD_SWITCH_OFF 3'h1
`define DCWD_CMD_SWITCH_ON 3'h2
`define DCWD_CMD_ENABLE_OP 3'h3
`define DCWD_CMD_QUICK_STOP 3'h4
`define DCWD_CMD_PULSE_INH 3'h5

// AXI response codes
`define DCWD_RESP_OKAY 2'h0
`define DCWD_RESP_SLVERR 2'h2

`endif

// ===== logic/dcwd_top.v
`timescale 1ns/100ps
`include "dcwd_consts.vh"

// Overview of operation
// - 16-bit command word, any value, resets zero
// - Decode switch-off, switch-on/disable, pulse inhibit
// - Bit2 low, bit1 high, bit7 low: quick stop
// - Bits 3..0 all high, bit7 low: enable operation
// - Irrelevant bits never change chosen command
// - Bits 4..6 pass to operating mode
// - Fault reset only on bit7 rising edge
// - Bit 8 high commands halt ramp
// - Bit 14 high releases holding brake
module dcwd_top (
    input wire aclk,
    input wire aresetn,
    input wire [15:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [15:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    output reg [2:0] cmd_code_ff,
    output reg cmd_strobe_ff,
    output reg fault_reset_ff,
    output reg [2:0] mode_bits_ff,
    output reg halt_ff,
    output reg brake_release_ff
);

    ////////////////////////////////////////////////////////////////////////////
    // Decode function

    // Priority decode of the committed word into a device-state command.
    // Fault reset is tested first, then pulse inhibit, so a cleared voltage bit
    // removes torque whatever bits 0, 2 and 3 ask for while bit 7 is low.
    function [2:0] dcwd_decode;
        input [15:0] w; // Committed command word
        begin
            if (w[`DCWD_BIT_FAULT_RST]) begin
                // Bit 7 high matches no state command, only fault reset
                dcwd_decode = `DCWD_CMD_NONE;
            end else if (!w[`DCWD_BIT_VOLTAGE]) begin
                // Voltage bit low: bits 0, 2 and 3 are irrelevant
                dcwd_decode = `DCWD_CMD_PULSE_INH;
            end else if (!w[`DCWD_BIT_NO_QSTOP]) begin
                // Quick stop looks at neither bit 0 nor bit 3
                dcwd_decode = `DCWD_CMD_QUICK_STOP;
            end else if (!w[`DCWD_BIT_SWITCH_ON]) begin
                // Switch-off does not look at bit 3
                dcwd_decode = `DCWD_CMD_SWITCH_OFF;
            end else if (w[`DCWD_BIT_ENABLE_OP]) begin
                // All four low bits set
                dcwd_decode = `DCWD_CMD_ENABLE_OP;
            end else begin
                // Switch on and disable operation share one pattern
                dcwd_decode = `DCWD_CMD_SWITCH_ON;
            end
        end
    endfunction

    // One item moves on a channel at an edge where valid meets ready
    function dcwd_hs;
        input valid; // Source offers an item
        input ready; // Sink can take it
        begin
            dcwd_hs = valid & ready;
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // State

    reg [15:0] cmd_word_ff; // Drive command word
    reg [15:0] nxt_cmd_word; // Word after the byte-lane merge
    reg aw_held_ff; // Write address captured
    reg [15:0] aw_addr_ff; // Captured write address
    reg w_held_ff; // Write data captured
    reg [31:0] w_data_ff; // Captured write data, upper half unused
    reg [3:0] w_strb_ff; // Captured byte strobes
    reg upd_ff; // Command word was just written
    reg prev_bit7_ff; // Last seen bit 7 for edge detection

    // Next values of the decoded outputs
    reg [2:0] nxt_cmd_code; // Held code, or a fresh decode
    reg nxt_cmd_strobe; // One pulse per accepted write
    reg nxt_fault_reset; // Rising edge of bit 7
    reg nxt_prev_bit7; // Bit 7 as it stands now
    reg [2:0] nxt_mode_bits; // Bits 6..4 for the operating mode
    reg nxt_halt; // Bit 8
    reg nxt_brake_release; // Bit 14

    // Next values of the read channel payload
    reg [31:0] nxt_rdata; // Data for the address just taken
    reg [1:0] nxt_rresp; // Response for that address

    // Handshake and commit conditions
    wire aw_take; // Write address moves at this edge
    wire w_take; // Write data moves at this edge
    wire b_take; // Write response is accepted at this edge
    wire ar_take; // Read address moves at this edge
    wire r_take; // Read data is accepted at this edge
    wire do_write; // Both write halves present, no response pending
    wire wr_hit; // Write targets the command word

    assign aw_take = dcwd_hs(s_axi_awvalid, s_axi_awready);
    assign w_take = dcwd_hs(s_axi_wvalid, s_axi_wready);
    assign b_take = dcwd_hs(s_axi_bvalid, s_axi_bready);
    assign ar_take = dcwd_hs(s_axi_arvalid, s_axi_arready);
    assign r_take = dcwd_hs(s_axi_rvalid, s_axi_rready);
    assign do_write = aw_held_ff && w_held_ff && !s_axi_bvalid;
    assign wr_hit = (aw_addr_ff == `DCWD_ADDR_CMD_WORD);

    ////////////////////////////////////////////////////////////////////////////
    // Byte-lane merge

    // Only the two low strobes matter; the word is 16 bits, so lanes 2 and 3
    // are accepted and dropped rather than refused
    always @* begin
        nxt_cmd_word = cmd_word_ff;
        if (w_strb_ff[0]) begin
            // Low byte: state command bits, mode bits, fault reset
            nxt_cmd_word[7:0] = w_data_ff[7:0];
        end
        if (w_strb_ff[1]) begin
            // High byte: halt, brake release and reserved bits
            nxt_cmd_word[15:8] = w_data_ff[15:8];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Write channels: address and data taken in either order

    // Each half is parked until its partner arrives; the response is issued
    // only once both are in, and the parking registers free on its handshake
    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_ff <= 1'h0;
            aw_addr_ff <= 16'h0000;
            w_held_ff <= 1'h0;
            w_data_ff <= 32'h00000000;
            w_strb_ff <= 4'h0;
            s_axi_awready <= 1'h0;
            s_axi_wready <= 1'h0;
            s_axi_bvalid <= 1'h0;
            s_axi_bresp <= `DCWD_RESP_OKAY;
            cmd_word_ff <= `DCWD_CMD_WORD_RST;
            upd_ff <= 1'h0;
        end else begin
            // Update flag lives for one cycle only
            upd_ff <= 1'h0;
            // Ready is offered one cycle ahead and dropped on the taking edge,
            // so each channel takes exactly one item per write
            s_axi_awready <= !aw_held_ff && !aw_take;
            s_axi_wready <= !w_held_ff && !w_take;
            if (aw_take) begin
                // Park the address
                aw_held_ff <= 1'h1;
                aw_addr_ff <= s_axi_awaddr;
            end
            if (w_take) begin
                // Park the data and its strobes
                w_held_ff <= 1'h1;
                w_data_ff <= s_axi_wdata;
                w_strb_ff <= s_axi_wstrb;
            end
            // Both halves present: commit and answer
            if (do_write) begin
                s_axi_bvalid <= 1'h1;
                if (wr_hit) begin
                    // Any 16-bit value is taken as written
                    cmd_word_ff <= nxt_cmd_word;
                    upd_ff <= 1'h1;
                    s_axi_bresp <= `DCWD_RESP_OKAY;
                end else begin
                    // Unmapped or read-only address: no effect
                    s_axi_bresp <= `DCWD_RESP_SLVERR;
                end
            end
            // Response taken: free both halves for the next write
            if (b_take) begin
                s_axi_bvalid <= 1'h0;
                aw_held_ff <= 1'h0;
                w_held_ff <= 1'h0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read channel

    // Read data selection; the status word lets software see the code, mode, halt and brake levels
    // the drive side was last handed, without a second copy of the decode
    always @* begin
        nxt_rdata = 32'h00000000;
        nxt_rresp = `DCWD_RESP_OKAY;
        case (s_axi_araddr)
            `DCWD_ADDR_CMD_WORD: begin
                // Word as written, upper half reads zero
                nxt_rdata = {16'h0000, cmd_word_ff};
            end
            `DCWD_ADDR_CMD_STAT: begin
                // Shows the held outputs: brake release, halt, mode bits and command code, not the strobe or fault pulse
                nxt_rdata = {24'h000000, brake_release_ff, halt_ff,
                             mode_bits_ff, cmd_code_ff};
            end
            default: begin
                // Nothing mapped here
                nxt_rdata = 32'h00000000;
                nxt_rresp = `DCWD_RESP_SLVERR;
            end
        endcase
    end

    // One read in flight; the address ready stays low while data waits
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'h0;
            s_axi_rvalid <= 1'h0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `DCWD_RESP_OKAY;
        end else begin
            s_axi_arready <= !s_axi_rvalid && !ar_take;
            if (ar_take) begin
                // Data and response stand until the master takes them
                s_axi_rvalid <= 1'h1;
                s_axi_rdata <= nxt_rdata;
                s_axi_rresp <= nxt_rresp;
            end else if (r_take) begin
                s_axi_rvalid <= 1'h0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Command outputs, all one cycle after the committed word

    // Next values of the drive-side outputs
    always @* begin
        // Decode only on a new write: one command per update
        nxt_cmd_strobe = upd_ff;
        nxt_cmd_code = cmd_code_ff;
        if (upd_ff) begin
            nxt_cmd_code = dcwd_decode(cmd_word_ff);
        end
        // Edge, not level: a held bit 7 must not repeat the reset
        nxt_prev_bit7 = cmd_word_ff[`DCWD_BIT_FAULT_RST];
        nxt_fault_reset = cmd_word_ff[`DCWD_BIT_FAULT_RST] && !prev_bit7_ff;
        // Mode bits play no part in the state decode
        nxt_mode_bits = cmd_word_ff[`DCWD_BIT_MODE_HI:`DCWD_BIT_MODE_LO];
        // Halt is a level: the ramp to zero runs while the bit stays set
        nxt_halt = cmd_word_ff[`DCWD_BIT_HALT];
        // Brake release is not gated by the command state; software that
        // sets it owns the hazard of an open brake on an idle power stage
        nxt_brake_release = cmd_word_ff[`DCWD_BIT_BRAKE];
    end

    // Register every drive-side output so none of them glitches
    always @(posedge aclk) begin
        if (!aresetn) begin
            cmd_code_ff <= `DCWD_CMD_NONE;
            cmd_strobe_ff <= 1'h0;
            fault_reset_ff <= 1'h0;
            // Idle level of bit 7, so no false edge follows reset
            prev_bit7_ff <= 1'h0;
            mode_bits_ff <= 3'h0;
            halt_ff <= 1'h0;
            brake_release_ff <= 1'h0;
        end else begin
            cmd_code_ff <= nxt_cmd_code;
            cmd_strobe_ff <= nxt_cmd_strobe;
            fault_reset_ff <= nxt_fault_reset;
            prev_bit7_ff <= nxt_prev_bit7;
            mode_bits_ff <= nxt_mode_bits;
            halt_ff <= nxt_halt;
            brake_release_ff <= nxt_brake_release;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Notes for integrators
    //
    // Decoded outputs lag the committed word by one cycle; the write
    //   response arrives one cycle before the strobe.
    // A command code stays put between writes, so a consumer that wants
    //   edges must watch the strobe, not the code.
    // Writing the same word twice strobes the same code twice; the state
    //   machine downstream must treat a repeat as harmless.
    // Fault reset is the only pulse not tied to a new code: it follows
    //   the rising edge of bit 7 in the committed word.
    // Partial writes keep the other byte, so bit 7 can rise from a
    //   low-byte write while halt and brake stay as they were.

endmodule // dcwd_top

// ===== verification/dcwd_host.sv
`timescale 1ns/100ps
// Register-bus master standing in for the cyclic fieldbus host
module dcwd_host (
    input logic aclk,
    input logic s_axi_awready,
    input logic s_axi_wready,
    input logic s_axi_bvalid,
    input logic s_axi_arready,
    input logic s_axi_rvalid,
    input logic [1:0] s_axi_bresp,
    input logic [1:0] s_axi_rresp,
    input logic [31:0] s_axi_rdata,
    output logic s_axi_awvalid,
    output logic s_axi_wvalid,
    output logic s_axi_bready,
    output logic s_axi_arvalid,
    output logic s_axi_rready,
    output logic [15:0] s_axi_awaddr,
    output logic [15:0] s_axi_araddr,
    output logic [31:0] s_axi_wdata,
    output logic [3:0] s_axi_wstrb
);
    // Idle bus, answers always accepted
    initial begin
        {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} <= 3'h0;
        {s_axi_bready, s_axi_rready, s_axi_wstrb} <= 6'h3f;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} <= 64'h0;
    end
    ////////////////////////////////////////
    // Word write; released lines show the inverse so stale values never pass
    task automatic wr(input logic [15:0] a, input logic [15:0] d, output logic [1:0] r);
        @(posedge aclk);
        {s_axi_awvalid, s_axi_wvalid, s_axi_awaddr, s_axi_wdata} <= {2'h3, a, 16'hffff, d};
        do begin
            @(posedge aclk);
            if (s_axi_awready) {s_axi_awvalid, s_axi_awaddr} <= {1'b0, ~a};
            if (s_axi_wready) {s_axi_wvalid, s_axi_wdata} <= {17'h0, ~d};
        end while (!s_axi_bvalid);
        r = s_axi_bresp;
    endtask
    // Word read
    task automatic rd(input logic [15:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        {s_axi_arvalid, s_axi_araddr} <= {1'b1, a};
        do begin
            @(posedge aclk);
            if (s_axi_arready) {s_axi_arvalid, s_axi_araddr} <= {1'b0, ~a};
        end while (!s_axi_rvalid);
        {d, r} = {s_axi_rdata, s_axi_rresp};
    endtask
endmodule // dcwd_host

// ===== verification/dcwd_chk_asserts.sv
`timescale 1ns/100ps
// Ties decoded outputs to accepted writes
module dcwd_chk (
    input logic aclk,
    input logic aresetn,
    input logic s_axi_awready,
    input logic s_axi_wready,
    input logic s_axi_bvalid,
    input logic cmd_strobe_ff,
    input logic fault_reset_ff,
    input logic halt_ff,
    input logic brake_release_ff,
    input logic [1:0] s_axi_bresp,
    input logic [2:0] cmd_code_ff,
    input logic [2:0] mode_bits_ff
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    a_strobe_single: assert property (cmd_strobe_ff |=> !cmd_strobe_ff)
        else $error("strobe too long");
    a_strobe_cause: assert property (cmd_strobe_ff |-> $past(s_axi_bvalid) && $past(s_axi_bresp) == 2'h0)
        else $error("strobe without write");
    a_write_decode: assert property ($rose(s_axi_bvalid) && s_axi_bresp == 2'h0 |=> cmd_strobe_ff)
        else $error("write not decoded");
    a_code_hold: assert property (!cmd_strobe_ff |-> $stable(cmd_code_ff))
        else $error("code moved");
    a_field_hold: assert property (!cmd_strobe_ff |-> $stable({mode_bits_ff, halt_ff, brake_release_ff}))
        else $error("fields moved");
    a_fault_pulse: assert property (fault_reset_ff |-> cmd_strobe_ff && cmd_code_ff == 3'h0 ##1 !fault_reset_ff)
        else $error("bad fault pulse");
    a_code_range: assert property (cmd_code_ff <= 3'h5)
        else $error("bad code");
    a_write_block: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken early");
    cover property (fault_reset_ff);
    cover property (cmd_strobe_ff && cmd_code_ff == 3'h4);
    cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
endmodule // dcwd_chk
bind dcwd_top dcwd_chk u_chk (.*);

// ===== verification/tb.sv
`timescale 1ns/100ps
// Word writes checked against a reference decode
module tb;
    logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic cmd_strobe_ff, fault_reset_ff, halt_ff, brake_release_ff;
    logic [1:0] s_axi_bresp, s_axi_rresp, rs;
    logic [2:0] cmd_code_ff, mode_bits_ff, ec;
    logic [3:0] s_axi_wstrb;
    logic [15:0] s_axi_awaddr, s_axi_araddr, cw, pw;
    logic [31:0] s_axi_wdata, s_axi_rdata, rdat;
    logic [15:0] tbl [10] = '{16'h0006, 16'h0007, 16'h000f, 16'h0002, 16'h000b, 16'h0080,
        16'h0080, 16'h0070, 16'h4100, 16'hffff};
    int failures = 0;
    int compares = 0;
    dcwd_top DUT (.*);
    dcwd_host u_host (.*);
    always #10 aclk = ~aclk;
    // Reference: bit 7 wins, then pulse inhibit, then quick stop
    function automatic logic [2:0] ref_code(input logic [15:0] v);
        if (v[7]) return 3'h0;
        if (!v[1]) return 3'h5;
        if (!v[2]) return 3'h4;
        if (!v[0]) return 3'h1;
        return v[3] ? 3'h3 : 3'h2;
    endfunction
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            failures++;
            $display("[ERR] %s exp %h got %h", n, e, g);
        end
    endtask
    task automatic print_verdict;
        if (failures == 0 && compares > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    initial begin
        #400000;
        failures++;
        print_verdict();
    end
    initial begin
        void'($urandom(82190));
        {aclk, aresetn, pw} = 18'h0;
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        u_host.rd(16'h6040, rdat, rs);
        chk("word", 0, rdat);
        for (int i = 0; i < 60; i++) begin
            cw = (i < 10) ? tbl[i] : 16'($urandom);
            ec = ref_code(cw);
            u_host.wr(16'h6040, cw, rs);
            chk("bresp", 0, rs);
            // Strobe and fault pulse stand only in the cycle after the response
            #1;
            chk("outs", {1'b1, ec, cw[7] & ~pw[7], cw[6:4], cw[8], cw[14]}, {cmd_strobe_ff, cmd_code_ff, fault_reset_ff, mode_bits_ff, halt_ff, brake_release_ff});
            u_host.rd(16'h6044, rdat, rs);
            chk("status", {cw[14], cw[8], cw[6:4], ec}, rdat);
            pw = cw;
        end
        u_host.wr(16'h6044, 16'h0000, rs);
        chk("bresp_ro", 2, rs);
        u_host.rd(16'h6040, rdat, rs);
        chk("word_kept", pw, rdat);
        u_host.rd(16'h6048, rdat, rs);
        chk("rresp_bad", 2, rs);
        print_verdict();
    end
endmodule // tb
